// ---- hw/dpbh_ctrl.v ----
// host-side controller for one port of a two-port static memory
// Operation
// R1: device writes while enable and strobe low
// R2: data held across terminating strobe rise
// R3: other port data settles after access
// R4: strobe held high through every read
// R5: address valid before enable falls
// R6: write pulse covers disable plus setup
// R7: late enable keeps outputs off
// R8: interrupt pin only on large packages
// R9: device lowers busy on address match
// R10: device raises busy on mismatch
// R11: address ahead of enable for priority
// R12: strobe lowered no earlier than busy; code lowers strobe one cycle after enable, before it first samples busy
// R13: strobe held low after busy rises
// R14: read data valid after busy rises
// R15: device sets interrupt after write
// R16: device clears interrupt on acknowledge
// R17: data only trusted after access time
// R18: only losing port sees busy
`timescale 1ns/1ns
`include "dpbh_consts.vh"

module dpbh_ctrl
(
   input  wire                   clk_sys_in,
   input  wire                   nrst_in,
   input  wire                   ce_in,
   input  wire                   req_in,
   input  wire                   we_in,
   input  wire [`DPBH_AW-1:0]    addr_in,
   input  wire [`DPBH_DW-1:0]    wdata_in,
   output reg                    ready_out,
   output reg                    done_out,
   output reg  [`DPBH_DW-1:0]    rdata_out,
   output reg                    waited_out,
   output reg                    irq_out,
   output reg                    mem_ce_n_out,
   output reg                    mem_oe_n_out,
   output reg                    mem_rw_n_out,
   output reg  [`DPBH_AW-1:0]    mem_addr_out,
   output reg  [`DPBH_DW-1:0]    mem_dq_out,
   output reg                    mem_dq_oe_out,
   input  wire [`DPBH_DW-1:0]    mem_dq_in,
   input  wire                   mem_busy_n_in,
   input  wire                   mem_int_n_in
);

   // ****************************************
   // states and wait counts
   // ****************************************
   localparam [9:0] S_IDLE   = 10'h001;
   localparam [9:0] S_SETUP  = 10'h002;
   localparam [9:0] S_RACC   = 10'h004;
   localparam [9:0] S_RBUSY  = 10'h008;
   localparam [9:0] S_RDATA  = 10'h010;
   localparam [9:0] S_WCE    = 10'h020;
   localparam [9:0] S_WPULSE = 10'h040;
   localparam [9:0] S_WBUSY  = 10'h080;
   localparam [9:0] S_WEND   = 10'h100;
   localparam [9:0] S_DONE   = 10'h200;

   // whole-number counts, cut to the timer width below
   localparam integer        C_AA_I  = `DPBH_TAA_CYC;
   localparam integer        C_BDD_I = `DPBH_TBDD_CYC;
   localparam integer        C_PW_I  = `DPBH_TPW_CYC;
   localparam integer        C_WH_I  = `DPBH_TWH_CYC;

   localparam [`DPBH_CW-1:0] C_AA  = C_AA_I[`DPBH_CW-1:0];
   localparam [`DPBH_CW-1:0] C_BDD = C_BDD_I[`DPBH_CW-1:0];
   localparam [`DPBH_CW-1:0] C_PW  = C_PW_I[`DPBH_CW-1:0];
   localparam [`DPBH_CW-1:0] C_WH  = C_WH_I[`DPBH_CW-1:0];

   reg  [9:0]            state_r;
   reg  [9:0]            state_nxt;
   reg                   is_wr_r;
   reg                   ld;
   reg  [`DPBH_CW-1:0]   ld_val;
   wire                  tmr_done;

   // ****************************************
   // wait timer
   // ****************************************
   dpbh_timer u_timer
   (
      .clk_sys_in (clk_sys_in),
      .nrst_in    (nrst_in),
      .en_in      (ce_in),
      .load_in    (ld),
      .value_in   (ld_val),
      .done_out   (tmr_done)
   );

   // ****************************************
   // next state
   // ****************************************
   always @*
   begin
      state_nxt = state_r;
      ld        = 1'b0;
      ld_val    = C_AA;
      case (state_r)
         S_IDLE:
            if (req_in)
               state_nxt = S_SETUP;
         S_SETUP:
         begin
            if (is_wr_r)
               state_nxt = S_WCE;
            else
            begin
               ld        = 1'b1;
               ld_val    = C_AA;
               state_nxt = S_RACC;
            end
         end
         S_RACC:
         begin
            // R14: contended read waits for busy release
            if (!mem_busy_n_in)
               state_nxt = S_RBUSY;
            // R17: capture only after full access time
            else if (tmr_done)
               state_nxt = S_DONE;
         end
         S_RBUSY:
            if (mem_busy_n_in)
            begin
               ld        = 1'b1;
               ld_val    = C_BDD;
               state_nxt = S_RDATA;
            end
         S_RDATA:
            if (tmr_done)
               state_nxt = S_DONE;
         S_WCE:
         begin
            // R6: pulse sized for disable plus setup
            ld        = 1'b1;
            ld_val    = C_PW;
            state_nxt = S_WPULSE;
         end
         S_WPULSE:
         begin
            // R12: busy checked only once strobe is low
            if (!mem_busy_n_in)
               state_nxt = S_WBUSY;
            else if (tmr_done)
               state_nxt = S_WEND;
         end
         S_WBUSY:
            // R13: extra low time after busy rises
            if (mem_busy_n_in)
            begin
               ld        = 1'b1;
               ld_val    = C_WH;
               state_nxt = S_WPULSE;
            end
         S_WEND:
            state_nxt = S_DONE;
         S_DONE:
            state_nxt = S_IDLE;
         default:
            state_nxt = S_IDLE;
      endcase
   end

   // ****************************************
   // state and pin registers
   // ****************************************
   always @(posedge clk_sys_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         state_r       <= S_IDLE;
         is_wr_r       <= 1'b0;
         ready_out     <= 1'b0;
         done_out      <= 1'b0;
         rdata_out     <= 8'h00;
         waited_out    <= 1'b0;
         irq_out       <= 1'b0;
         mem_ce_n_out  <= 1'b1;
         mem_oe_n_out  <= 1'b1;
         mem_rw_n_out  <= 1'b1;
         mem_addr_out  <= 11'h000;
         mem_dq_out    <= 8'h00;
         mem_dq_oe_out <= 1'b0;
      end
      else if (ce_in)
      begin
         state_r   <= state_nxt;
         ready_out <= (state_nxt == S_IDLE);
         done_out  <= 1'b0;
         // R15: interrupt level passed to the user
         irq_out   <= ~mem_int_n_in;
         case (state_r)
            S_IDLE:
               if (req_in)
               begin
                  // R11: address goes out a cycle before enable
                  is_wr_r      <= we_in;
                  mem_addr_out <= addr_in;
                  mem_dq_out   <= wdata_in;
                  mem_rw_n_out <= 1'b1;
                  waited_out   <= 1'b0;
                  ready_out    <= 1'b0;
               end
            S_SETUP:
            begin
               // R5: address already stable when enable falls
               mem_ce_n_out <= 1'b0;
               // R4: strobe stays high, output enable only on reads
               mem_oe_n_out <= is_wr_r;
            end
            S_RACC, S_RDATA:
               if (state_nxt == S_DONE)
               begin
                  rdata_out    <= mem_dq_in;
                  mem_ce_n_out <= 1'b1;
                  mem_oe_n_out <= 1'b1;
               end
            S_RBUSY:
               waited_out <= 1'b1;
            S_WCE:
            begin
               // R7: enable fell first so the port may be written
               mem_rw_n_out  <= 1'b0;
               mem_dq_oe_out <= 1'b1;
            end
            S_WBUSY:
               waited_out <= 1'b1;
            S_WPULSE:
               // R1: strobe rise ends the internal write
               if (state_nxt == S_WEND)
                  mem_rw_n_out <= 1'b1;
            S_WEND:
            begin
               // R2: data held one cycle past strobe rise
               mem_ce_n_out  <= 1'b1;
               mem_dq_oe_out <= 1'b0;
            end
            S_DONE:
               done_out <= 1'b1;
            default:
               mem_ce_n_out <= 1'b1;
         endcase
      end
   end

endmodule

// ---- hw/dpbh_consts.vh ----
// timing and width constants for the dual-port memory port controller
`ifndef DPBH_CONSTS_VH
`define DPBH_CONSTS_VH

// ****************************************
// widths
// ****************************************
`define DPBH_AW 11
`define DPBH_DW 8
`define DPBH_CW 6

// ****************************************
// clock and device times in ns
// ****************************************
`define DPBH_CLK_NS 4
`define DPBH_TAA_NS 35
`define DPBH_TBDD_NS 35
`define DPBH_TPWE_NS 25
`define DPBH_THZWE_NS 20
`define DPBH_TSD_NS 15
`define DPBH_TWH_NS 30

// ****************************************
// derived cycle counts, least times round up
// ****************************************
`define DPBH_CYC(ns) (((ns) + `DPBH_CLK_NS - 1) / `DPBH_CLK_NS)
`define DPBH_TAA_CYC `DPBH_CYC(`DPBH_TAA_NS)
`define DPBH_TBDD_CYC `DPBH_CYC(`DPBH_TBDD_NS)
`define DPBH_TWH_CYC `DPBH_CYC(`DPBH_TWH_NS)
`define DPBH_PW_NS ((`DPBH_TPWE_NS > (`DPBH_THZWE_NS + `DPBH_TSD_NS)) ? \
   `DPBH_TPWE_NS : (`DPBH_THZWE_NS + `DPBH_TSD_NS))
`define DPBH_TPW_CYC `DPBH_CYC(`DPBH_PW_NS)

`endif

// ---- hw/dpbh_timer.v ----
// down counter that marks the end of a device wait
`timescale 1ns/1ns
`include "dpbh_consts.vh"

module dpbh_timer
(
   input  wire                   clk_sys_in,
   input  wire                   nrst_in,
   input  wire                   en_in,
   input  wire                   load_in,
   input  wire [`DPBH_CW-1:0]    value_in,
   output wire                   done_out
);

   reg  [`DPBH_CW-1:0] cnt_r;

   assign done_out = (cnt_r == {`DPBH_CW{1'b0}});

   always @(posedge clk_sys_in or negedge nrst_in)
   begin
      if (!nrst_in)
         cnt_r <= {`DPBH_CW{1'b0}};
      else if (en_in)
      begin
         if (load_in)
            cnt_r <= value_in;
         else if (!done_out)
            cnt_r <= cnt_r - 6'h01;
      end
   end

endmodule

// ---- tb/dpbh_props.sv ----
// pin-level assertions for the memory port controller
`timescale 1ns/1ns
`include "dpbh_consts.vh"

module dpbh_props
(
   input wire                clk_sys_in,
   input wire                nrst_in,
   input wire                done_out,
   input wire                mem_ce_n_out,
   input wire                mem_oe_n_out,
   input wire                mem_rw_n_out,
   input wire [`DPBH_AW-1:0] mem_addr_out,
   input wire [`DPBH_DW-1:0] mem_dq_out,
   input wire                mem_dq_oe_out,
   input wire                mem_busy_n_in
);
   reg  [3:0]                low_cnt_r;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   always @(posedge clk_sys_in or negedge nrst_in)
      if (!nrst_in)
         low_cnt_r <= 4'h0;
      else if (mem_rw_n_out)
         low_cnt_r <= 4'h0;
      else if (low_cnt_r != 4'hF)
         low_cnt_r <= low_cnt_r + 4'h1;
   wr_needs_ce_a: assert property (!mem_rw_n_out |-> !mem_ce_n_out)
      else $error("strobe low without enable");
   rd_rw_high_a: assert property (!mem_oe_n_out |-> mem_rw_n_out
      && !mem_dq_oe_out) else $error("read without strobe high");
   ce_addr_set_a: assert property ($fell(mem_ce_n_out)
      |-> $stable(mem_addr_out)) else $error("address moved at enable");
   addr_hold_a: assert property (!mem_ce_n_out && !$past(mem_ce_n_out)
      |-> $stable(mem_addr_out)) else $error("address moved in access");
   data_hold_a: assert property ($rose(mem_rw_n_out) |-> mem_dq_oe_out
      && $stable(mem_dq_out)) else $error("data lost at write end");
   pulse_width_a: assert property ($rose(mem_rw_n_out)
      |-> low_cnt_r >= `DPBH_TPW_CYC) else $error("write pulse short");
   busy_hold_a: assert property ($rose(mem_busy_n_in) && !mem_rw_n_out
      |-> !mem_rw_n_out [*8]) else $error("strobe rose early");
   done_idle_a: assert property (done_out |-> mem_ce_n_out
      && mem_rw_n_out && !mem_dq_oe_out) else $error("pins busy at done");
endmodule

bind dpbh_ctrl dpbh_props u_props
   (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .done_out(done_out),
    .mem_ce_n_out(mem_ce_n_out), .mem_oe_n_out(mem_oe_n_out),
    .mem_rw_n_out(mem_rw_n_out), .mem_addr_out(mem_addr_out),
    .mem_dq_out(mem_dq_out), .mem_dq_oe_out(mem_dq_oe_out),
    .mem_busy_n_in(mem_busy_n_in));

// ---- tb/dpbh_mem_model.sv ----
// behavioural model of one memory port
`timescale 1ns/1ns
`include "dpbh_consts.vh"

module dpbh_mem_model
(
   input  wire                clk_sys_in,
   input  wire                ce_n_in,
   input  wire                oe_n_in,
   input  wire                rw_n_in,
   input  wire                busy_n_in,
   input  wire [`DPBH_AW-1:0] addr_in,
   input  wire [`DPBH_DW-1:0] dq_in,
   output wire [`DPBH_DW-1:0] dq_out
);
   reg  [`DPBH_DW-1:0] mem_r [0:(1<<`DPBH_AW)-1];
   reg  [`DPBH_DW-1:0] last_r = 8'h5A;
   reg  [3:0]          age_r = 4'h0;
   wire                rd_on = !ce_n_in && !oe_n_in && rw_n_in;
   always @(posedge clk_sys_in)
      if (!ce_n_in && !rw_n_in && busy_n_in)
         mem_r[addr_in] <= dq_in;
   always @(posedge clk_sys_in)
   begin
      age_r <= (rd_on && busy_n_in && age_r < 4'hF) ? age_r + 4'h1 : 4'h0;
      last_r <= dq_out;
   end
   assign dq_out = (rd_on && age_r >= 4'h8) ? mem_r[addr_in] : ~last_r;
endmodule

// ---- tb/dpbh_ctrl_tb.sv ----
// self-checking bench for the memory port controller
`timescale 1ns/1ns
`include "dpbh_consts.vh"
`define CHK(n, e, g) begin total_checks = total_checks + 1; \
   if ((e) !== (g)) begin err_total = err_total + 1; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end

module dpbh_ctrl_tb;
   reg                 clk_sys_in = 0, nrst_in = 0, ce_in = 1;
   reg                 req_in = 0, we_in = 0, busy_n = 1, int_n = 1;
   reg  [`DPBH_AW-1:0] addr_in = 0;
   reg  [`DPBH_DW-1:0] wdata_in = 0, exp_r [0:15];
   wire [`DPBH_DW-1:0] rdata, dq_o, dq_i;
   wire [`DPBH_AW-1:0] ma;
   wire                rdy, done, waited, irq, ce_n, oe_n, rw_n, dq_oe;
   integer             seed = 32'h1627516d, err_total = 0;
   integer             total_checks = 0, cyc = 0, i;
   always #2 clk_sys_in = ~clk_sys_in;
   dpbh_ctrl DUT (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ce_in(ce_in),
      .req_in(req_in), .we_in(we_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .ready_out(rdy), .done_out(done), .rdata_out(rdata),
      .waited_out(waited), .irq_out(irq), .mem_ce_n_out(ce_n),
      .mem_oe_n_out(oe_n), .mem_rw_n_out(rw_n), .mem_addr_out(ma),
      .mem_dq_out(dq_o), .mem_dq_oe_out(dq_oe), .mem_dq_in(dq_i),
      .mem_busy_n_in(busy_n), .mem_int_n_in(int_n));
   dpbh_mem_model u_mem (.clk_sys_in(clk_sys_in), .ce_n_in(ce_n),
      .oe_n_in(oe_n), .rw_n_in(rw_n), .busy_n_in(busy_n), .addr_in(ma),
      .dq_in(dq_o), .dq_out(dq_i));
   function [7:0] exp_of(input [3:0] k);
      exp_of = exp_r[k];
   endfunction
   // cycles from take to done seen, busy dropped on the fourth edge
   function integer exp_lat(input w, input integer b);
   begin
      if (b > 0)
         exp_lat = 4 + b + (w ? `DPBH_TWH_CYC + 3 : `DPBH_TBDD_CYC + 2);
      else
         exp_lat = w ? `DPBH_TPW_CYC + 5 : `DPBH_TAA_CYC + 3;
   end
   endfunction
   task print_verdict;
   begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask
   // busy held low b cycles after f frozen cycles; top index hits 7FF
   task xfer(input w, input [3:0] k, input [7:0] d, input integer b,
      input integer f);
      integer n;
   begin
      n = 0;
      while (rdy !== 1'b1)
         @(negedge clk_sys_in);
      we_in = w;
      addr_in = {k, 7'h7F};
      wdata_in = d;
      req_in = 1;
      @(negedge clk_sys_in);
      req_in = 0;
      repeat (3) @(negedge clk_sys_in);
      if (f > 0)
      begin
         ce_in = 0;
         repeat (f) @(negedge clk_sys_in);
         ce_in = 1;
      end
      if (b > 0)
      begin
         busy_n = 0;
         repeat (b) @(negedge clk_sys_in);
         busy_n = 1;
      end
      while (done !== 1'b1 && n < 200)
      begin
         @(negedge clk_sys_in);
         n = n + 1;
      end
      `CHK("done", 1'b1, done)
      `CHK("waited", b != 0, waited)
      `CHK("cycles", exp_lat(w, b) + f, 3 + f + b + n)
      if (w)
         exp_r[k] = d;
      else
         `CHK("rdata", exp_of(k), rdata)
      @(negedge clk_sys_in);
      `CHK("done pulse", 1'b0, done)
   end
   endtask
   always @(posedge clk_sys_in)
   begin
      cyc = cyc + 1;
      if (cyc == 8000)
      begin
         err_total = err_total + 1;
         print_verdict;
      end
   end
   initial
   begin
      repeat (12) @(negedge clk_sys_in);
      nrst_in = 1;
      for (i = 0; i < 16; i = i + 1)
         xfer(1, i, $random(seed), 0, 0);
      $display("test fill ends");
      for (i = 0; i < 60; i = i + 1)
         xfer($random(seed), $random(seed), $random(seed), i % 4,
            $random(seed) & 3);
      $display("test random ends");
      // interrupt pin of the large package
      int_n = 0;
      repeat (2) @(negedge clk_sys_in);
      `CHK("irq set", 1'b1, irq)
      int_n = 1;
      repeat (2) @(negedge clk_sys_in);
      `CHK("irq clear", 1'b0, irq)
      $display("test irq ends");
      print_verdict;
   end
endmodule
